// File: twe_pkg.sv
// Constants, state encoding and timing for the two-wire EEPROM write target.
// Assumes a 100 MHz system clock and a bus clock that arrives from the controller.
// Notes on behaviour
// R1 - Data changes only while clock low; changes with clock high mean start or stop.
// R2 - Falling data with clock high is a start; every command begins with one.
// R3 - Rising data with clock high is a stop; it returns the device to standby.
// R4 - Words are eight bits, MSB first; device pulls data low on ninth clock.
// R5 - Standby after power-up, and after stop once any programming has finished.
// R6 - Start, nine clocks, start, stop recovers the device for a new transfer.
// R7 - Device address word carries the fixed one-zero-one-zero type prefix.
// R8 - Next three address bits must match the three strapped select pins.
// R9 - Last address bit selects direction: high read, low write.
// R10 - Matching address is acknowledged; mismatch gets no acknowledge and standby.
// R11 - Write-protect high protects the whole array against writes.
// R12 - Byte write: two word-address bytes then one data byte, each acknowledged.
// R13 - Stop after acknowledged data starts self-timed programming.
// R14 - During programming the inputs are disabled and the bus gets no response.
// R15 - Programming lasts at most five milliseconds from the stop.
// R16 - Page write: up to 63 further data bytes, each acknowledged.
// R17 - After each data byte only the low six address bits advance.
// R18 - Beyond 64 bytes the address wraps within the page, overwriting data.
// R19 - Polling address is acknowledged only after programming has completed.
// R20 - Data bits sampled on rising clock, outgoing bits changed after falling.
// R21 - Memory is 256 pages of 64 bytes under a 14-bit word address.
// R22 - Write-protect low allows writes; high inhibits every array write.
// R23 - Top two bits of the first word-address byte are ignored.
// R24 - Data line released whenever the device is not acknowledging.
package twe_pkg;

    localparam int unsigned CLK_FREQ_HZ         = 100_000_000;
    localparam int unsigned NVM_PROGRAM_TIME_MS = 5;
    localparam int unsigned NVM_PROGRAM_CYCLES  = NVM_PROGRAM_TIME_MS * (CLK_FREQ_HZ / 1000);

    localparam int unsigned WORD_ADDR_BITS = 14;
    localparam int unsigned PAGE_OFS_BITS  = 6;
    localparam int unsigned PAGE_BYTES     = 64;
    localparam int unsigned MEM_BYTES      = 16384;
    localparam int unsigned HI_ADDR_BITS   = 6;

    localparam logic [3:0] DEV_TYPE_PREFIX = 4'ha;
    localparam logic [3:0] BITS_PER_WORD   = 4'h8;
    localparam logic [3:0] LAST_DATA_BIT   = 4'h7;

    localparam logic [WORD_ADDR_BITS-1:0] WORD_ADDR_RESET = 14'h0000;
    localparam logic [PAGE_BYTES-1:0]     MASK_RESET      = 64'h0;

    typedef enum logic [2:0] {
        TWE_ST_STANDBY,
        TWE_ST_DEV_ADDR,
        TWE_ST_ADDR_HI,
        TWE_ST_ADDR_LO,
        TWE_ST_DATA,
        TWE_ST_IGNORE
    } twe_state_type;

endpackage

// File: twe_link_rx.sv
// Bit capture on the bus clock: one data bit per rising edge plus a toggle.
// Assumes the system side reads the held bit only after seeing the toggle move.
`timescale 1ns/10ps
module twe_link_rx (
    input  wire logic scl,
    input  wire logic rstn,
    input  wire logic sda_in,
    output logic      bit_val,
    output logic      bit_tgl
);
    import twe_pkg::*;

    logic bit_val_nxt;
    logic bit_tgl_nxt;

    always_comb begin
        bit_val_nxt = sda_in; // R20
        bit_tgl_nxt = ~bit_tgl;
    end

    // Bit held a full bus period, long enough for the toggle to cross first.
    // Bus clock stands still during reset, so reset acts without it; release
    // is safe only while the bus clock idles.
    always_ff @(posedge scl or negedge rstn) begin
        if (!rstn) begin
            bit_val <= 1'b1;
            bit_tgl <= 1'b0;
        end else begin
            bit_val <= bit_val_nxt;
            bit_tgl <= bit_tgl_nxt;
        end
    end

endmodule

// File: twe_target.sv
// Two-wire EEPROM target: bus conditions, addressing, page write and programming.
// Assumes open-drain wiring outside; sda_out is always low and sda_oe pulls it.
`timescale 1ns/10ps
module twe_target #(
    parameter int unsigned PROGRAM_CYCLES = twe_pkg::NVM_PROGRAM_CYCLES
) (
    input  wire logic                               sys_clk,
    input  wire logic                               rstn,
    input  wire logic                               scl,
    input  wire logic                               sda_in,
    output logic                                    sda_out,
    output logic                                    sda_oe,
    input  wire logic                               addr_strap_bit2,
    input  wire logic                               addr_strap_bit1,
    input  wire logic                               addr_strap_bit0,
    input  wire logic                               write_protect,
    input  wire logic [twe_pkg::WORD_ADDR_BITS-1:0] mem_rd_addr,
    output logic [7:0]                              mem_rd_data,
    output logic                                    standby,
    output logic                                    nvm_busy
);
    import twe_pkg::*;

    localparam int unsigned CW = $clog2(PROGRAM_CYCLES + 1);
    localparam logic [CW-1:0] PROG_LAST = CW'(PROGRAM_CYCLES - 1);

    logic [7:0] nvm_mem [MEM_BYTES];
    logic [7:0] page_buf [PAGE_BYTES];

    logic link_bit;
    logic link_tgl;

    twe_link_rx u_link_rx (
        .scl     (scl),
        .rstn    (rstn),
        .sda_in  (sda_in),
        .bit_val (link_bit),
        .bit_tgl (link_tgl)
    );

    // Pin synchronisers; first stages feed only the second
    logic       scl_s1_r;
    logic       scl_s2_r;
    logic       scl_d_r;
    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       sda_d_r;
    logic       tgl_s1_r;
    logic       tgl_s2_r;
    logic       tgl_d_r;
    logic [2:0] strap_s1_r;
    logic [2:0] strap_s2_r;
    logic       wp_s1_r;
    logic       wp_s2_r;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            scl_s1_r   <= 1'b1;
            scl_s2_r   <= 1'b1;
            scl_d_r    <= 1'b1;
            sda_s1_r   <= 1'b1;
            sda_s2_r   <= 1'b1;
            sda_d_r    <= 1'b1;
            tgl_s1_r   <= 1'b0;
            tgl_s2_r   <= 1'b0;
            tgl_d_r    <= 1'b0;
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
            wp_s1_r    <= 1'b0;
            wp_s2_r    <= 1'b0;
        end else begin
            scl_s1_r   <= scl;
            scl_s2_r   <= scl_s1_r;
            scl_d_r    <= scl_s2_r;
            sda_s1_r   <= sda_in;
            sda_s2_r   <= sda_s1_r;
            sda_d_r    <= sda_s2_r;
            tgl_s1_r   <= link_tgl;
            tgl_s2_r   <= tgl_s1_r;
            tgl_d_r    <= tgl_s2_r;
            strap_s1_r <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2_r <= strap_s1_r;
            wp_s1_r    <= write_protect;
            wp_s2_r    <= wp_s1_r;
        end
    end

    // Both lines share one sync depth, so start and stop keep their order
    logic start_ev;
    logic stop_ev;
    logic scl_fall;
    logic bit_ev;

    always_comb begin
        start_ev = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;  // R1 R2
        stop_ev  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;  // R1 R3
        scl_fall = scl_d_r & ~scl_s2_r;
        bit_ev   = tgl_s2_r ^ tgl_d_r;
    end

    // Protocol state
    twe_state_type             state_r;
    twe_state_type             state_nxt;
    logic [3:0]                cnt_r;
    logic [3:0]                cnt_nxt;
    logic [7:0]                shreg_r;
    logic [7:0]                shreg_nxt;
    logic                      ack_pend_r;
    logic                      ack_pend_nxt;
    logic                      in_ack_r;
    logic                      in_ack_nxt;
    logic                      oe_r;
    logic                      oe_nxt;
    logic                      rw_r;
    logic                      rw_nxt;
    logic [WORD_ADDR_BITS-1:0] addr_r;
    logic [WORD_ADDR_BITS-1:0] addr_nxt;
    logic [PAGE_BYTES-1:0]     mask_r;
    logic [PAGE_BYTES-1:0]     mask_nxt;
    logic                      buf_we;
    logic [PAGE_OFS_BITS-1:0]  buf_wa;
    logic [7:0]                byte_in;
    logic                      prog_go;

    // Programming state
    logic                      busy_r;
    logic                      busy_nxt;
    logic [CW-1:0]             busy_cnt_r;
    logic [CW-1:0]             busy_cnt_nxt;
    logic                      commit_r;
    logic                      commit_nxt;
    logic [PAGE_OFS_BITS-1:0]  commit_idx_r;
    logic [PAGE_OFS_BITS-1:0]  commit_idx_nxt;
    logic                      mem_we;

    always_comb begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        shreg_nxt    = shreg_r;
        ack_pend_nxt = ack_pend_r;
        in_ack_nxt   = in_ack_r;
        oe_nxt       = oe_r;
        rw_nxt       = rw_r;
        addr_nxt     = addr_r;
        mask_nxt     = mask_r;
        buf_we       = 1'b0;
        buf_wa       = addr_r[PAGE_OFS_BITS-1:0];
        byte_in      = {shreg_r[6:0], link_bit};
        prog_go      = 1'b0;

        if (start_ev) begin
            // Repeated start drops any unfinished page
            state_nxt    = TWE_ST_DEV_ADDR; // R2 R6
            cnt_nxt      = 4'h0;
            ack_pend_nxt = 1'b0;
            in_ack_nxt   = 1'b0;
            oe_nxt       = 1'b0;
            mask_nxt     = MASK_RESET;
        end else if (stop_ev) begin
            // Empty or protected pages end here with no programming cycle
            if (state_r == TWE_ST_DATA && (|mask_r) && !wp_s2_r && !busy_r) begin
                prog_go = 1'b1; // R13 R11 R22
            end
            state_nxt    = TWE_ST_STANDBY; // R3 R5 R6
            ack_pend_nxt = 1'b0;
            in_ack_nxt   = 1'b0;
            oe_nxt       = 1'b0; // R24
            mask_nxt     = MASK_RESET;
        end else begin
            if (bit_ev && state_r != TWE_ST_STANDBY) begin
                if (cnt_r == BITS_PER_WORD) begin
                    cnt_nxt = 4'h0; // R4
                end else begin
                    shreg_nxt = byte_in; // R4
                    cnt_nxt   = cnt_r + 4'h1;
                end
                if (cnt_r == LAST_DATA_BIT) begin
                    unique case (state_r)
                        TWE_ST_DEV_ADDR: begin
                            if (byte_in[7:4] == DEV_TYPE_PREFIX     // R7
                                && byte_in[3:1] == strap_s2_r       // R8
                                && !busy_r) begin                   // R14 R19
                                ack_pend_nxt = 1'b1; // R10
                                rw_nxt       = byte_in[0];
                                // Reads are not built here; a read is acked then idles
                                state_nxt    = byte_in[0] ? TWE_ST_IGNORE : TWE_ST_ADDR_HI; // R9
                            end else begin
                                state_nxt = TWE_ST_STANDBY; // R10
                            end
                        end
                        TWE_ST_ADDR_HI: begin
                            addr_nxt[WORD_ADDR_BITS-1:8] = byte_in[HI_ADDR_BITS-1:0]; // R23 R21
                            ack_pend_nxt = 1'b1; // R12
                            state_nxt    = TWE_ST_ADDR_LO;
                        end
                        TWE_ST_ADDR_LO: begin
                            addr_nxt[7:0] = byte_in; // R21
                            ack_pend_nxt  = 1'b1; // R12
                            state_nxt     = TWE_ST_DATA;
                        end
                        TWE_ST_DATA: begin
                            buf_we               = 1'b1;
                            mask_nxt[buf_wa]     = 1'b1; // R18
                            addr_nxt[PAGE_OFS_BITS-1:0] = addr_r[PAGE_OFS_BITS-1:0] + 6'h1; // R17
                            ack_pend_nxt         = 1'b1; // R12 R16
                        end
                        TWE_ST_IGNORE: begin
                        end
                        default: begin
                            state_nxt = TWE_ST_STANDBY;
                        end
                    endcase
                end
            end
            // Line moves only after the clock has fallen
            if (scl_fall) begin
                if (ack_pend_r) begin
                    oe_nxt       = 1'b1; // R4 R20
                    in_ack_nxt   = 1'b1;
                    ack_pend_nxt = 1'b0;
                end else if (in_ack_r) begin
                    oe_nxt     = 1'b0; // R24 R20
                    in_ack_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_r    <= TWE_ST_STANDBY; // R5
            cnt_r      <= 4'h0;
            shreg_r    <= 8'h00;
            ack_pend_r <= 1'b0;
            in_ack_r   <= 1'b0;
            oe_r       <= 1'b0;
            rw_r       <= 1'b0;
            addr_r     <= WORD_ADDR_RESET;
            mask_r     <= MASK_RESET;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            shreg_r    <= shreg_nxt;
            ack_pend_r <= ack_pend_nxt;
            in_ack_r   <= in_ack_nxt;
            oe_r       <= oe_nxt;
            rw_r       <= rw_nxt;
            addr_r     <= addr_nxt;
            mask_r     <= mask_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (buf_we) begin
            page_buf[buf_wa] <= byte_in; // R18
        end
    end

    // Commit copies one page byte per cycle, well inside the programming time.
    // The page mask and page row are frozen because the bus is ignored meanwhile.
    logic [PAGE_BYTES-1:0]            commit_mask_r;
    logic [PAGE_BYTES-1:0]            commit_mask_nxt;
    logic [WORD_ADDR_BITS-PAGE_OFS_BITS-1:0] commit_page_r;
    logic [WORD_ADDR_BITS-PAGE_OFS_BITS-1:0] commit_page_nxt;

    always_comb begin
        busy_nxt        = busy_r;
        busy_cnt_nxt    = busy_cnt_r;
        commit_nxt      = commit_r;
        commit_idx_nxt  = commit_idx_r;
        commit_mask_nxt = commit_mask_r;
        commit_page_nxt = commit_page_r;
        // Bytes not received this page leave the array untouched
        mem_we          = commit_r & commit_mask_r[commit_idx_r];
        // Loaded one short so busy spans exactly the full count
        if (prog_go) begin
            busy_nxt        = 1'b1; // R13 R14
            busy_cnt_nxt    = PROG_LAST; // R15
            commit_nxt      = 1'b1;
            commit_idx_nxt  = 6'h0;
            commit_mask_nxt = mask_r;
            commit_page_nxt = addr_r[WORD_ADDR_BITS-1:PAGE_OFS_BITS]; // R17
        end else if (busy_r) begin
            if (busy_cnt_r == '0) begin
                busy_nxt = 1'b0; // R15 R19
            end else begin
                busy_cnt_nxt = busy_cnt_r - CW'(1);
            end
            if (commit_r) begin
                commit_idx_nxt = commit_idx_r + 6'h1;
                if (commit_idx_r == 6'h3f) begin
                    commit_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            busy_r        <= 1'b0;
            busy_cnt_r    <= '0;
            commit_r      <= 1'b0;
            commit_idx_r  <= 6'h0;
            commit_mask_r <= MASK_RESET;
            commit_page_r <= '0;
        end else begin
            busy_r        <= busy_nxt;
            busy_cnt_r    <= busy_cnt_nxt;
            commit_r      <= commit_nxt;
            commit_idx_r  <= commit_idx_nxt;
            commit_mask_r <= commit_mask_nxt;
            commit_page_r <= commit_page_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (mem_we) begin
            nvm_mem[{commit_page_r, commit_idx_r}] <= page_buf[commit_idx_r];
        end
    end

    // Outputs straight from flops
    // Debug read port only; unprogrammed bytes read as unknown
    always_ff @(posedge sys_clk) begin
        mem_rd_data <= nvm_mem[mem_rd_addr];
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sda_out  <= 1'b0;
            sda_oe   <= 1'b0; // R24
            standby  <= 1'b1;
            nvm_busy <= 1'b0;
        end else begin
            sda_out  <= 1'b0;
            // From oe_nxt so the pin moves with the state, not a cycle after
            sda_oe   <= oe_nxt;
            standby  <= (state_nxt == TWE_ST_STANDBY) & ~busy_nxt; // R5
            nvm_busy <= busy_nxt;
        end
    end

endmodule

// File: twe_target_asserts.sv
// Checker for the two-wire target: bus conditions, ack and programming.
// Assumes binding to twe_target; bus pins are sampled as levels on sys_clk.
`timescale 1ns/10ps
module twe_target_asserts #(
    parameter int unsigned PROGRAM_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic standby,
    input wire logic nvm_busy
);
    logic [31:0] busy_cnt_r;
    logic [31:0] busy_cnt_nxt;

    always_comb begin
        busy_cnt_nxt = nvm_busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
    always_ff @(posedge sys_clk) begin
        busy_cnt_r <= rstn ? busy_cnt_nxt : 32'h0;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_start;
        scl && $past(scl) && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda_in);
    endsequence
    // Whole ninth clock: rise then fall of the bus clock
    sequence s_ack_clock;
        ##[1:20] $rose(scl) ##[1:20] $fell(scl);
    endsequence

    chk_busy_standby: assert property (nvm_busy |-> !standby)
        else $error("standby high while programming");
    chk_busy_no_ack: assert property (nvm_busy |-> !sda_oe)
        else $error("ack driven while programming");
    chk_busy_max: assert property (busy_cnt_r <= PROGRAM_CYCLES)
        else $error("programming ran too long");
    chk_busy_exact: assert property ($fell(nvm_busy) |-> busy_cnt_r == PROGRAM_CYCLES)
        else $error("programming length wrong");
    chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("data line changed with clock high");
    chk_ack_hold: assert property ($rose(sda_oe) |-> sda_oe throughout s_ack_clock)
        else $error("ack dropped inside ninth clock");
    chk_start_wake: assert property (s_start |-> ##[1:8] !standby)
        else $error("start not taken");
    chk_stop_idle: assert property (s_stop |-> ##[1:8] (standby || nvm_busy))
        else $error("stop left device active");
    chk_oe_active: assert property (sda_oe |-> !standby && !sda_out)
        else $error("line pulled outside a transfer");
    chk_prog_at_stop: assert property ($rose(nvm_busy) |-> scl && sda_in)
        else $error("programming began without stop");
endmodule

bind twe_target twe_target_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .standby(standby), .nvm_busy(nvm_busy));

// File: twe_ctrl_model.sv
// Bus controller model: clocks frames and pulls the data line low.
// Assumes a pull-up on the data line; the clock stands high between frames.
`timescale 1ns/10ps
module twe_ctrl_model #(
    parameter realtime Q = 31.25
) (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic do_start();
        if (!scl) begin
            #(Q) sda_pull = 1'b0;
            #(Q) scl = 1'b1;
        end
        #(2*Q) sda_pull = 1'b1;
        #(2*Q) scl = 1'b0;
    endtask
    task automatic do_stop();
        #(Q) sda_pull = 1'b1;
        #(Q) scl = 1'b1;
        #(2*Q) sda_pull = 1'b0;
        #(2*Q);
    endtask
    // Data set a quarter period after the fall keeps a 125 ns bit
    task automatic clock_bit(input logic b, output logic s);
        #(Q) sda_pull = ~b;
        #(Q) scl = 1'b1;
        s = sda;
        #(2*Q) scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic recover();
        logic s;
        do_start();
        repeat (9) clock_bit(1'b1, s);
        do_start();
        do_stop();
    endtask
endmodule

// File: twe_target_tb.sv
// Bench for the two-wire EEPROM write target, driven by a controller model.
// Assumes a pull-up on the data line and a shortened programming count.
`timescale 1ns/10ps
module twe_target_tb;
    import twe_pkg::*;
    localparam int unsigned PROG = 200;
    logic                      sys_clk;
    logic                      rstn;
    logic                      scl;
    logic                      sda;
    logic                      sda_pull;
    logic                      sda_out;
    logic                      sda_oe;
    logic                      wp;
    logic                      standby;
    logic                      nvm_busy;
    logic                      ack;
    logic [2:0]                strap;
    logic [15:0]               wa;
    logic [WORD_ADDR_BITS-1:0] rd_addr;
    logic [7:0]                rd_data;
    logic [7:0]                exp_mem [int];
    int                        bad_count;
    int                        check_count;

    assign sda = ~sda_pull & ~(sda_oe & ~sda_out);
    always #5 sys_clk = ~sys_clk;

    twe_target #(.PROGRAM_CYCLES(PROG)) DUT (
        .sys_clk(sys_clk), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_strap_bit2(strap[2]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit0(strap[0]), .write_protect(wp), .mem_rd_addr(rd_addr),
        .mem_rd_data(rd_data), .standby(standby), .nvm_busy(nvm_busy));
    twe_ctrl_model CTL (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    function automatic logic [7:0] dev_word(input logic [2:0] s, input logic rd);
        return {DEV_TYPE_PREFIX, s, rd};
    endfunction
    task automatic wait_idle();
        int n;
        n = 0;
        while (nvm_busy !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        if (n >= 400) begin
            bad_count++;
            $display("[ERR] %0t programming never ended", $time);
            give_verdict();
        end
        tick(4);
    endtask
    task automatic after_stop(input logic busy_exp);
        tick(3);
        check(nvm_busy, busy_exp, "busy after stop");
    endtask
    task automatic poll(input logic [7:0] w, input logic exp_ack);
        CTL.do_start();
        CTL.send_byte(w, ack);
        check(ack, exp_ack, "address ack");
        CTL.do_stop();
    endtask
    task automatic write_page(input logic [15:0] a, input int n);
        logic [7:0] d;
        logic [5:0] ofs;
        poll_open: begin
            CTL.do_start();
            CTL.send_byte(dev_word(strap, 1'b0), ack);
            check(ack, 1'b1, "device ack");
        end
        CTL.send_byte(a[15:8], ack);
        check(ack, 1'b1, "address high ack");
        CTL.send_byte(a[7:0], ack);
        check(ack, 1'b1, "address low ack");
        ofs = a[5:0];
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            CTL.send_byte(d, ack);
            check(ack, 1'b1, "data ack");
            if (!wp) exp_mem[int'({a[13:6], ofs})] = d;
            ofs++;
        end
        CTL.do_stop();
    endtask
    task automatic check_mem();
        foreach (exp_mem[a]) begin
            rd_addr = a[13:0];
            tick(1);
            check(rd_data, exp_mem[a], "array byte");
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b1;
        wp = 1'b0;
        rd_addr = '0;
        bad_count = 0;
        check_count = 0;
        void'($urandom(32'h8e7f));
        strap = 3'($urandom);
        // Reset falls after time zero so the bus-side reset edge is seen
        #1 rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        tick(6);
        check(standby, 1'b1, "standby after reset");
        check(sda_oe, 1'b0, "line released");
        check(sda_out, 1'b0, "line drive level");
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            write_page(16'($urandom), 1);
            after_stop(1'b1);
            check(standby, 1'b0, "standby while busy");
            poll(dev_word(strap, 1'b0), 1'b0);
            wait_idle();
            poll(dev_word(strap, 1'b0), 1'b1);
            after_stop(1'b0);
        end
        check_mem();
        $display("test byte write done");
        for (int s = 0; s < 8; s++) poll(dev_word(3'(s), 1'b0), 3'(s) == strap);
        poll({4'h5, strap, 1'b0}, 1'b0);
        poll({4'hb, strap, 1'b0}, 1'b0);
        check(standby, 1'b1, "standby after mismatch");
        poll(dev_word(strap, 1'b1), 1'b1);
        after_stop(1'b0);
        $display("test addressing done");
        wa = {2'($urandom), 8'($urandom), 6'h3e};
        write_page(wa, 66);
        after_stop(1'b1);
        wait_idle();
        check_mem();
        $display("test page wrap done");
        wp = 1'b1;
        tick(4);
        // Over the wrapped page, so a leaked write would show
        write_page(wa, 3);
        after_stop(1'b0);
        check_mem();
        wp = 1'b0;
        $display("test protect done");
        strap = 3'($urandom);
        tick(4);
        CTL.do_start();
        CTL.send_byte(dev_word(strap, 1'b0), ack);
        check(ack, 1'b1, "ack before abort");
        CTL.clock_bit(1'b0, ack);
        CTL.recover();
        tick(4);
        check(standby, 1'b1, "standby after recovery");
        write_page(16'($urandom), 2);
        after_stop(1'b1);
        wait_idle();
        check_mem();
        $display("test recovery done");
        give_verdict();
    end
endmodule
